// *** design/stsc_config.v ***
// Symbol time and sampling configuration register with its control logic
`timescale 1ns/100ps
`include "stsc_regs.vh"
module stsc_config #(
	parameter NFAULT = 8,
	parameter NSRC   = 8
) (
	input  wire              sys_clk_in,
	input  wire              nrst_in,
	input  wire [1:0]        comm_mode_in,
	input  wire              psi5_prog_in,
	input  wire [7:0]        reg_addr_in,
	input  wire [7:0]        reg_wdata_in,
	input  wire              reg_wr_in,
	input  wire              reg_rd_in,
	output reg  [7:0]        reg_rdata_out,
	output reg               array_err_out,
	input  wire              selftest_start_in,
	input  wire              selftest_done_in,
	input  wire              selftest_pass_in,
	output reg               selftest_retry_out,
	output reg               selftest_fail_flag_out,
	input  wire [NFAULT-1:0] fault_raw_in,
	output reg  [NFAULT-1:0] fault_out,
	input  wire              periodic_response_start_in,
	input  wire              dsi3_bus_in,
	input  wire              psi5_slot_start_in,
	input  wire              psi5_sync_in,
	input  wire              spi_cs_n_in,
	input  wire [2:0]        source_identifier_in,
	input  wire [NSRC-1:0]   source_enable_in,
	output reg               sample_ref_out,
	output reg  [NSRC-1:0]   sample_src_out,
	input  wire              crm_active_in,
	input  wire              tx_active_in,
	output reg  [8:0]        symbol_cycles_out,
	output reg               slew_en_out,
	output reg               symbol_tick_out
);
	// Self-test retry states
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_DONE = 3'b100;

	// Fixed symbol periods in clock cycles, cut to the period width on use
	localparam integer CRM_CYC  = `STSC_CYC(`STSC_CRM_CHIP_NS);
	localparam integer SLOW_CYC = `STSC_CYC(`STSC_PSI5_SLOW_NS);
	localparam integer FAST_CYC = `STSC_CYC(`STSC_PSI5_FAST_NS);

	reg  [7:0]       cfg_q;
	reg              par_q;
	reg  [2:0]       st_state_q;
	reg  [3:0]       st_tries_q;
	reg  [1:0]       bus_sync_q;
	reg  [1:0]       sync_sync_q;
	reg  [1:0]       cs_sync_q;
	reg              bus_prev_q;
	reg              sync_prev_q;
	reg              cs_prev_q;
	wire             is_dsi3;
	wire             is_psi5;
	wire             is_spi;
	wire             acc_ok;
	wire             hit;
	wire             ss_en;
	wire [3:0]       code;
	wire             bus_fall;
	wire             sync_rise;
	wire             cs_fall;
	wire [2:0]       lowest;
	wire [3:0]       limit;
	wire [3:0]       tries_nx;
	reg  [8:0]       period_d;
	reg              slew_d;
	wire             tick;

	assign is_dsi3  = (comm_mode_in == `STSC_MODE_DSI3);
	assign is_psi5  = (comm_mode_in == `STSC_MODE_PSI5);
	assign is_spi   = (comm_mode_in == `STSC_MODE_SPI);
	assign acc_ok   = !is_psi5 || psi5_prog_in; // R17
	assign hit      = (reg_addr_in == `STSC_CFG_ADDR) && acc_ok;
	assign ss_en    = cfg_q[`STSC_SS_BIT];
	assign code     = cfg_q[`STSC_CODE_MSB:`STSC_CODE_LSB];
	assign bus_fall = bus_prev_q && !bus_sync_q[1];
	assign sync_rise = !sync_prev_q && sync_sync_q[1];
	assign cs_fall  = cs_prev_q && !cs_sync_q[1];
	assign lowest   = lowest_src(source_enable_in);
	assign limit    = rpt_limit(cfg_q[`STSC_RPT_MSB:`STSC_RPT_LSB]);
	assign tries_nx = st_tries_q + 4'h1;

	// Maximum self-test attempts per repeat code
	function [3:0] rpt_limit;
		input [1:0] c;
		begin
			case (c)
			2'h0:    rpt_limit = 4'h8;
			2'h1:    rpt_limit = 4'h1;
			2'h2:    rpt_limit = 4'h4;
			default: rpt_limit = 4'h2;
			endcase
		end
	endfunction

	// Index of the lowest enabled source, zero when none is enabled
	function [2:0] lowest_src;
		input [NSRC-1:0] en;
		integer i;
		begin
			lowest_src = 3'h0;
			for (i = NSRC - 1; i >= 0; i = i - 1) begin
				if (en[i]) begin
					lowest_src = i[2:0];
				end
			end
		end
	endfunction

	// Periodic-collection chip time in clock cycles
	function [8:0] chip_cycles;
		input [3:0] c;
		begin
			case (c)
			4'h0:    chip_cycles = 9'd50;
			4'h1:    chip_cycles = 9'd100;
			4'h2:    chip_cycles = 9'd125;
			4'h3:    chip_cycles = 9'd130;
			4'h4:    chip_cycles = 9'd130;
			4'h5:    chip_cycles = 9'd135;
			4'h6:    chip_cycles = 9'd140;
			4'h7:    chip_cycles = 9'd145;
			4'h8:    chip_cycles = 9'd150;
			4'h9:    chip_cycles = 9'd155;
			4'ha:    chip_cycles = 9'd160;
			4'hb:    chip_cycles = 9'd165;
			4'hc:    chip_cycles = 9'd175;
			4'hd:    chip_cycles = 9'd200;
			4'he:    chip_cycles = 9'd225;
			default: chip_cycles = 9'd250;
			endcase
		end
	endfunction

	// Register storage with a parity shadow for array error detection
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg_q         <= `STSC_CFG_RESET;
			par_q         <= ^`STSC_CFG_RESET;
			reg_rdata_out <= 8'h00;
			array_err_out <= 1'b0;
		end else begin
			if (reg_wr_in && hit) begin
				cfg_q <= reg_wdata_in; // R17
				par_q <= ^reg_wdata_in; // R17
			end
			reg_rdata_out <= (reg_rd_in && hit) ? cfg_q : 8'h00;
			array_err_out <= (^cfg_q) ^ par_q; // R17
		end
	end

	// Startup self-test retry control, PSI5 only
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_state_q             <= ST_IDLE;
			st_tries_q             <= 4'h0;
			selftest_retry_out     <= 1'b0;
			selftest_fail_flag_out <= 1'b0;
		end else begin
			selftest_retry_out <= 1'b0;
			case (st_state_q)
			ST_IDLE: begin
				if (selftest_start_in && is_psi5) begin
					st_tries_q <= 4'h0;
					st_state_q <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (selftest_done_in) begin
					if (selftest_pass_in) begin
						st_state_q <= ST_DONE;
					end else if (tries_nx >= limit) begin
						selftest_fail_flag_out <= 1'b1; // R1
						st_state_q             <= ST_DONE;
					end else begin
						st_tries_q         <= tries_nx; // R1
						selftest_retry_out <= 1'b1; // R1
					end
				end
			end
			ST_DONE: begin
				st_state_q <= ST_DONE;
			end
			default: begin
				st_state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// Latching only outside PSI5 would defeat recovery, so it is mode-gated
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fault_out <= {NFAULT{1'b0}};
		end else if (is_psi5 && cfg_q[`STSC_LATCH_BIT]) begin
			fault_out <= fault_out | fault_raw_in; // R2
		end else begin
			fault_out <= fault_raw_in; // R3
		end
	end

	// Pin synchronisers; only the second stage is examined
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bus_sync_q  <= 2'b11;
			sync_sync_q <= 2'b00;
			cs_sync_q   <= 2'b11;
			bus_prev_q  <= 1'b1;
			sync_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			bus_sync_q  <= {bus_sync_q[0], dsi3_bus_in};
			sync_sync_q <= {sync_sync_q[0], psi5_sync_in};
			cs_sync_q   <= {cs_sync_q[0], spi_cs_n_in};
			bus_prev_q  <= bus_sync_q[1];
			sync_prev_q <= sync_sync_q[1];
			cs_prev_q   <= cs_sync_q[1];
		end
	end

	// Data latency reference strobes
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sample_ref_out <= 1'b0;
			sample_src_out <= {NSRC{1'b0}};
		end else begin
			sample_ref_out <= 1'b0;
			sample_src_out <= {NSRC{1'b0}};
			case (comm_mode_in)
			`STSC_MODE_DSI3: begin
				if (ss_en) begin
					sample_ref_out <= bus_fall; // R5
				end else begin
					sample_ref_out <= periodic_response_start_in; // R4
				end
			end
			`STSC_MODE_PSI5: begin
				if (ss_en) begin
					sample_ref_out <= sync_rise; // R7
				end else begin
					sample_ref_out <= psi5_slot_start_in; // R6
				end
			end
			`STSC_MODE_SPI: begin
				if (cs_fall && !ss_en) begin
					sample_src_out[source_identifier_in] <= 1'b1; // R8
				end else if (cs_fall && source_identifier_in == lowest) begin
					sample_src_out <= source_enable_in; // R9 R10 R11
				end
			end
			default: begin
				sample_ref_out <= 1'b0; // R12
			end
			endcase
		end
	end

	// Symbol period and slew selection
	always @* begin
		period_d = chip_cycles(code); // R14
		slew_d   = (code > 4'h1); // R14
		if (is_dsi3 && crm_active_in) begin
			period_d = CRM_CYC[8:0]; // R13
			slew_d   = 1'b1; // R13
		end else if (is_psi5) begin
			period_d = code[3] ? SLOW_CYC[8:0] : FAST_CYC[8:0]; // R15
			slew_d   = 1'b1; // R15
		end else if (!is_dsi3) begin
			period_d = 9'd0; // R16
			slew_d   = 1'b0; // R16
		end
	end

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			symbol_cycles_out <= 9'd0;
			slew_en_out       <= 1'b0;
			symbol_tick_out   <= 1'b0;
		end else begin
			symbol_cycles_out <= period_d;
			slew_en_out       <= slew_d;
			symbol_tick_out   <= tick;
		end
	end

	stsc_symbol_timer #(
		.W(9)
	) u_timer (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.run_in     (tx_active_in && (is_dsi3 || is_psi5)),
		.period_in  (symbol_cycles_out),
		.tick_out   (tick)
	);
endmodule

// *** design/stsc_regs.vh ***
// Constants for the symbol time and sampling configuration register
// Operation
// R1: PSI5 self-test retries limited; flag on exhaustion
// R2: Latch enable set: faults held until reset; code latches in PSI5 mode only
// R3: Latch enable clear: faults clear when recovered
// R4: DSI3 synchronous: latency from response start
// R5: DSI3 simultaneous: latency from command falling edge
// R6: PSI5 synchronous: latency from own time slot
// R7: PSI5 simultaneous: latency from sync pulse
// R8: SPI synchronous: sample per own source request
// R9: SPI simultaneous: all sample on first source
// R10: First source disabled: use lowest enabled source
// R11: Others refresh only when lowest source requested
// R12: I2C mode: sampling bit stored, no effect
// R13: DSI3 command-response: 5 us chip, slew on
// R14: DSI3 periodic chip time from code table
// R15: PSI5 bit time 5.3 or 8.0 us, slew on
// R16: SPI and I2C: chip time code ignored
// R17: Access in allowed modes; parity-checked contents
`ifndef STSC_REGS_VH
`define STSC_REGS_VH

`define STSC_CFG_ADDR      8'h23
`define STSC_CFG_RESET     8'h00
`define STSC_RPT_MSB       7
`define STSC_RPT_LSB       6
`define STSC_LATCH_BIT     5
`define STSC_SS_BIT        4
`define STSC_CODE_MSB      3
`define STSC_CODE_LSB      0

`define STSC_MODE_DSI3     2'h0
`define STSC_MODE_PSI5     2'h1
`define STSC_MODE_SPI      2'h2
`define STSC_MODE_I2C      2'h3

`define STSC_CLK_NS        20
`define STSC_CRM_CHIP_NS   5000
`define STSC_PSI5_FAST_NS  5300
`define STSC_PSI5_SLOW_NS  8000
`define STSC_CYC(ns)       ((ns) / `STSC_CLK_NS)

`endif

// *** design/stsc_symbol_timer.v ***
// Symbol-rate enable divider driven by a period count
`timescale 1ns/100ps
module stsc_symbol_timer #(
	parameter W = 9
) (
	input  wire         sys_clk_in,
	input  wire         nrst_in,
	input  wire         run_in,
	input  wire [W-1:0] period_in,
	output reg          tick_out
);
	reg [W-1:0] cnt_q;

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q    <= {W{1'b0}};
			tick_out <= 1'b0;
		end else if (!run_in) begin
			cnt_q    <= {W{1'b0}};
			tick_out <= 1'b0;
		end else if (cnt_q >= period_in - {{(W-1){1'b0}}, 1'b1}) begin
			cnt_q    <= {W{1'b0}};
			tick_out <= 1'b1;
		end else begin
			cnt_q    <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			tick_out <= 1'b0;
		end
	end
endmodule

// *** testbench/stsc_config_sva.sv ***
// Port checks for the configuration block
`timescale 1ns/100ps
module stsc_config_sva #(
	parameter NFAULT = 8,
	parameter NSRC   = 8
) (
	input wire              sys_clk_in,
	input wire              nrst_in,
	input wire [1:0]        comm_mode_in,
	input wire              psi5_prog_in,
	input wire [7:0]        reg_addr_in,
	input wire [7:0]        reg_wdata_in,
	input wire              reg_wr_in,
	input wire              reg_rd_in,
	input wire [7:0]        reg_rdata_out,
	input wire [NFAULT-1:0] fault_raw_in,
	input wire [NFAULT-1:0] fault_out,
	input wire              crm_active_in,
	input wire [8:0]        symbol_cycles_out,
	input wire              slew_en_out,
	input wire [NSRC-1:0]   source_enable_in,
	input wire [NSRC-1:0]   sample_src_out,
	input wire              sample_ref_out,
	input wire              selftest_fail_flag_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	reg  [7:0] cfg_q;
	wire       acc = reg_addr_in == 8'h23 &&
		(comm_mode_in != 2'h1 || psi5_prog_in);
	wire       lat = comm_mode_in == 2'h1 && cfg_q[5];
	// Shadow of the stored byte; refused writes leave it alone
	always @(posedge sys_clk_in or negedge nrst_in)
		if (!nrst_in)
			cfg_q <= 8'h00;
		else if (reg_wr_in && acc)
			cfg_q <= reg_wdata_in;
	AST_RD_DATA: assert property (
		reg_rd_in |=> reg_rdata_out == ($past(acc) ? cfg_q : 8'h00))
		else $error("read data wrong");
	AST_FAULT_HOLD: assert property (
		lat |=> fault_out == ($past(fault_raw_in) | $past(fault_out)))
		else $error("fault not held");
	AST_FAULT_FOLLOW: assert property (
		!lat |=> fault_out == $past(fault_raw_in))
		else $error("fault not following");
	AST_CRM_CHIP: assert property (
		comm_mode_in == 2'h0 && crm_active_in |=>
		symbol_cycles_out == 9'h0fa && slew_en_out)
		else $error("command chip time wrong");
	AST_PSI5_BIT: assert property (
		comm_mode_in == 2'h1 |=> slew_en_out &&
		symbol_cycles_out == ($past(cfg_q[3]) ? 9'h190 : 9'h109))
		else $error("bit time wrong");
	AST_NO_SYMBOL: assert property (
		comm_mode_in[1] |=> symbol_cycles_out == 9'h000)
		else $error("symbol time in serial mode");
	AST_I2C_QUIET: assert property (
		(comm_mode_in == 2'h3) [*5] |=> !sample_ref_out && !(|sample_src_out))
		else $error("sampling in i2c mode");
	AST_SPI_OWN: assert property (
		comm_mode_in == 2'h2 && !cfg_q[4] |-> $onehot0(sample_src_out))
		else $error("several own strobes");
	AST_SPI_ALL: assert property (
		comm_mode_in == 2'h2 && cfg_q[4] && |sample_src_out |->
		sample_src_out == source_enable_in)
		else $error("joint strobe wrong");
	AST_FAIL_STICKY: assert property (
		selftest_fail_flag_out |=> selftest_fail_flag_out)
		else $error("fail flag dropped");
endmodule
bind stsc_config stsc_config_sva #(.NFAULT(NFAULT), .NSRC(NSRC)) u_sva (.*);

// *** testbench/stsc_master_model.sv ***
// Bus master model: command edge, sync pulse and select frames
`timescale 1ns/100ps
module stsc_master_model (
	input  wire       sys_clk_in,
	input  wire [1:0] req_in,
	input  wire [3:0] len_in,
	output reg        dsi3_bus_out  = 1'b1,
	output reg        psi5_sync_out = 1'b0,
	output reg        spi_cs_n_out  = 1'b1
);
	// A busy frame swallows new requests; len_in makes a slow master
	always @(posedge sys_clk_in)
		if (req_in != 2'h0) begin
			#1;
			dsi3_bus_out = req_in != 2'h1;
			psi5_sync_out = req_in == 2'h2;
			spi_cs_n_out = req_in != 2'h3;
			repeat (len_in + 2) @(posedge sys_clk_in);
			#1;
			{dsi3_bus_out, psi5_sync_out, spi_cs_n_out} = 3'h5;
		end
endmodule

// *** testbench/stsc_config_tb.sv ***
// Self-checking bench for the configuration block
`timescale 1ns/100ps
module stsc_config_tb;
	logic       sys_clk_in = '0, nrst_in = '0, psi5_prog_in = '0;
	logic       reg_wr_in = '0, reg_rd_in = '0, selftest_start_in = '0;
	logic       selftest_done_in = '0, selftest_pass_in = '0;
	logic       periodic_response_start_in = '0, psi5_slot_start_in = '0;
	logic       crm_active_in = '0, tx_active_in = '0;
	logic [1:0] comm_mode_in = '0, req = '0;
	logic [2:0] source_identifier_in = '0;
	logic [3:0] len = '0;
	logic [7:0] reg_addr_in = '0, reg_wdata_in = '0, fault_raw_in = '0;
	logic [7:0] source_enable_in = '0, srcacc = '0;
	wire        dsi3_bus_in, psi5_sync_in, spi_cs_n_in, slew_en_out;
	wire        selftest_retry_out, selftest_fail_flag_out, array_err_out;
	wire        sample_ref_out, symbol_tick_out;
	wire [7:0]  reg_rdata_out, fault_out, sample_src_out;
	wire [8:0]  symbol_cycles_out;
	integer     n_fail = 0, checks_done = 0, seed = 32'h71c2306e;
	integer     i, k, r, nref, nret;
	localparam [127:0] TENTHS = 128'h0a14191a1a1b1c1d1e1f202123282d32;
	stsc_config uut (.*);
	stsc_master_model u_master (
		.sys_clk_in   (sys_clk_in),
		.req_in       (req),
		.len_in       (len),
		.dsi3_bus_out (dsi3_bus_in),
		.psi5_sync_out(psi5_sync_in),
		.spi_cs_n_out (spi_cs_n_in)
	);
	initial begin
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		nref = nref + sample_ref_out;
		srcacc = srcacc | sample_src_out;
	end
	function automatic [3:0] lim(input [1:0] c);
		lim = c == 2'h0 ? 4'h8 : c == 2'h1 ? 4'h1 : c == 2'h2 ? 4'h4 : 4'h2;
	endfunction
	function automatic [2:0] low(input [7:0] en);
		low = 3'h0;
		for (int j = 7; j >= 0; j--)
			if (en[j])
				low = j[2:0];
	endfunction
	function automatic [7:0] src_exp(input s, input [2:0] id, input [7:0] en);
		src_exp = !s ? 8'h01 << id : id == low(en) ? en : 8'h00;
	endfunction
	task automatic chk(input string nm, input [15:0] seen, input [15:0] e);
		checks_done++;
		if (seen !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic cyc(input integer c);
		repeat (c) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic rst;
		nrst_in = 1'b0;
		cyc(20);
		nrst_in = 1'b1;
	endtask
	task automatic wr(input [7:0] d);
		reg_addr_in = 8'h23;
		reg_wdata_in = d;
		pulse(reg_wr_in);
	endtask
	task automatic rd(input [7:0] a, input [7:0] e);
		reg_addr_in = a;
		pulse(reg_rd_in);
		chk("rdata", reg_rdata_out, e);
		cyc(1);
	endtask
	task automatic frame(input [1:0] q);
		r = $random(seed);
		len = r[3:0];
		req = q;
		cyc(1);
		req = 2'h0;
	endtask
	task automatic samp(input [1:0] m, input s, input [1:0] w);
		comm_mode_in = m;
		psi5_prog_in = 1'b1;
		wr({3'h0, s, 4'h0});
		psi5_prog_in = 1'b0;
		nref = 0;
		if (w == 2'h0)
			pulse(periodic_response_start_in);
		else if (w == 2'h1)
			pulse(psi5_slot_start_in);
		else
			frame(w - 2'h1);
		cyc(24);
		chk("ref", nref[15:0], (m == 2'h0 && w == {s, 1'b0}) ||
			(m == 2'h1 && w == {s, 1'b1}));
	endtask
	task automatic wait_tick(output integer c);
		c = 0;
		do begin
			cyc(1);
			c++;
		end while (symbol_tick_out !== 1'b1 && c < 999);
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// The run needs some 1500 cycles; twenty times that means a hang
	initial begin
		#600000;
		n_fail++;
		tally_and_finish;
	end
	initial begin
		rst();
		rd(8'h23, 8'h00);
		k = $random(seed);
		wr(k[7:0]);
		rd(8'h23, k[7:0]);
		rd(8'h24, 8'h00);
		comm_mode_in = 2'h1;
		wr(~k[7:0]);
		rd(8'h23, 8'h00);
		psi5_prog_in = 1'b1;
		rd(8'h23, k[7:0]);
		chk("parity", array_err_out, 16'h0);
		for (i = 0; i < 16; i++) begin
			comm_mode_in = 2'h0;
			wr({4'h0, i[3:0]});
			cyc(2);
			chk("chip", symbol_cycles_out, TENTHS[8*(15-i) +: 8] * 16'h5);
			chk("slew", slew_en_out, i > 1);
			comm_mode_in = 2'h1;
			cyc(2);
			chk("bit", symbol_cycles_out, i > 7 ? 16'h190 : 16'h109);
			comm_mode_in = {1'b1, i[0]};
			cyc(2);
			chk("serial", {slew_en_out, symbol_cycles_out}, 16'h0);
		end
		crm_active_in = 1'b1;
		comm_mode_in = 2'h0;
		cyc(2);
		chk("crm", {slew_en_out, symbol_cycles_out}, 16'h2fa);
		crm_active_in = 1'b0;
		wr(8'h00);
		tx_active_in = 1'b1;
		wait_tick(k);
		wait_tick(k);
		chk("tick gap", k[15:0], 16'h32);
		for (i = 0; i < 4; i++) begin
			rst();
			comm_mode_in = 2'h1;
			psi5_prog_in = 1'b1;
			wr({i[1:0], 6'h00});
			psi5_prog_in = 1'b0;
			pulse(selftest_start_in);
			nret = 0;
			for (k = 0; k < 9 && selftest_fail_flag_out !== 1'b1; k++) begin
				cyc(($random(seed) & 3) + 1);
				pulse(selftest_done_in);
				nret = nret + selftest_retry_out;
				cyc(1);
				nret = nret + selftest_retry_out;
			end
			chk("attempts", k[15:0], lim(i[1:0]));
			chk("retries", nret[15:0], lim(i[1:0]) - 4'h1);
		end
		// A passed attempt ends retry control; a later failure is ignored
		rst();
		comm_mode_in = 2'h1;
		psi5_prog_in = 1'b1;
		wr(8'h40);
		psi5_prog_in = 1'b0;
		pulse(selftest_start_in);
		selftest_pass_in = 1'b1;
		pulse(selftest_done_in);
		selftest_pass_in = 1'b0;
		cyc(1);
		pulse(selftest_done_in);
		cyc(1);
		chk("pass", {selftest_retry_out, selftest_fail_flag_out}, 16'h0);
		for (i = 0; i < 2; i++) begin
			psi5_prog_in = 1'b1;
			wr({2'h0, i[0], 5'h00});
			k = $random(seed);
			fault_raw_in = k[7:0];
			cyc(2);
			fault_raw_in = 8'h00;
			cyc(2);
			chk("faults", fault_out, i ? k[7:0] : 8'h00);
		end
		for (i = 0; i < 24; i++)
			samp({i[4], i[4] | i[3]}, i[2], i[1:0]);
		for (i = 0; i < 12; i++) begin
			comm_mode_in = 2'h2;
			k = $random(seed);
			source_enable_in = k[7:0];
			source_identifier_in = i % 3 ? low(k[7:0]) : k[10:8];
			wr({3'h0, i[0], 4'h0});
			srcacc = 8'h00;
			frame(2'h3);
			cyc(24);
			chk("src", srcacc,
				src_exp(i[0], source_identifier_in, k[7:0]));
		end
		tally_and_finish;
	end
endmodule
